// *** adsc_pkg.sv ***
// Package of constants and types for the converter sequencing control.
package adsc_pkg;

  localparam int RES_W      = 10;
  localparam int CHS_W      = 6;
  localparam int CLK_MHZ    = 50;
  localparam int CONV_TADS  = 11;
  localparam int CHS_RST    = 0;
  localparam int PREF_RST   = 0;
  localparam logic [5:0] CHS_TEMP = 6'h3c;
  localparam logic [5:0] CHS_DAC  = 6'h3d;
  localparam logic [5:0] CHS_FVR  = 6'h3e;
  localparam logic [5:0] CHS_GND  = 6'h3f;

  localparam logic [1:0] PREF_PIN    = 2'h0;
  localparam logic [1:0] PREF_SUPPLY = 2'h1;
  localparam logic [1:0] PREF_FVR2   = 2'h2;
  localparam logic [1:0] PREF_FVR4   = 2'h3;

  localparam logic [2:0] CCS_DIV2  = 3'h0;
  localparam logic [2:0] CCS_DIV8  = 3'h1;
  localparam logic [2:0] CCS_DIV32 = 3'h2;
  localparam logic [2:0] CCS_DIV4  = 3'h4;
  localparam logic [2:0] CCS_DIV16 = 3'h5;
  localparam logic [2:0] CCS_DIV64 = 3'h6;
  localparam logic [2:0] CCS_RST   = 3'h0;

  typedef enum {ST_IDLE, ST_CONV, ST_DONE} adsc_state_e;

endpackage : adsc_pkg

// *** adsc_tick_if.sv ***
// Interface carrying the conversion clock tick between modules.
`timescale 1ns/1ns
interface adsc_tick_if;
  logic [2:0] sel;
  logic       rc_tick;
  logic       run;
  logic       tick;
  modport gen (input sel, input rc_tick, input run, output tick);
  modport use_ (output sel, output rc_tick, output run, input tick);
endinterface : adsc_tick_if

// *** adsc_tick_gen.sv ***
// Conversion clock tick generator: divides the system clock or passes RC.
`timescale 1ns/1ns
module adsc_tick_gen
  import adsc_pkg::*;
(
  input wire logic    CLK,
  input wire logic    RST_N,
  adsc_tick_if.gen    tif
);

  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  logic [5:0] lim;
  logic       use_rc;
  logic       wrap;

  // ************************************************************
  // Divider limit decode.
  // ************************************************************
  assign use_rc = (tif.sel[1:0] == 2'h3);
  assign lim = (tif.sel == CCS_DIV2)  ? 6'h01 :
               (tif.sel == CCS_DIV4)  ? 6'h03 :
               (tif.sel == CCS_DIV8)  ? 6'h07 :
               (tif.sel == CCS_DIV16) ? 6'h0f :
               (tif.sel == CCS_DIV32) ? 6'h1f : 6'h3f;
  assign wrap    = (cnt_ff == lim);
  assign nxt_cnt = (!tif.run || wrap) ? 6'h00 : cnt_ff + 6'h01;
  assign tif.tick = tif.run && (use_rc ? tif.rc_tick : wrap); // [RL13]

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      cnt_ff <= 6'h00;
    else
      cnt_ff <= nxt_cnt;
  end

endmodule : adsc_tick_gen

// *** adsc_ctrl.sv ***
// Top of the converter sequencing control: mux, references, SAR, results.
//
// Functional notes
// [RL1] Convert the held sample into 10 bits by successive approximation.
// [RL2] Every input goes through one mux into the single sample-and-hold.
// [RL3] Completion raises an interrupt that can also wake from Sleep.
// [RL4] A 6-bit channel field picks the input fed to the sample-and-hold.
// [RL5] Inputs: analog pins, temperature, DAC output, fixed reference, ground.
// [RL6] Software waits an acquisition delay after a channel change.
// [RL7] Software should select ground before moving to a lower channel.
// [RL8] Two-bit field picks positive reference; 4.096V absent on low-voltage.
// [RL9] One bit picks the negative reference: pin or ground.
// [RL10] Software sets a pin's direction and analog bits before converting.
// [RL11] Enable first, set go later, never both at once.
// [RL12] Completion clears go, sets the flag, loads result; software clears flag.
// [RL13] Conversion clock is system clock divided or RC; eleven periods each.
// [RL14] A format bit left- or right-justifies the result in the pair.
// [RL15] Reference codes: 00 pin, 01 supply, 10 2.048V, 11 4.096V.
// [RL16] Reset clears everything, turns off, abandons conversion unstored.
`timescale 1ns/1ns
module adsc_ctrl
  import adsc_pkg::*;
#(
  parameter int  NPINS   = 60,
  parameter bit  HAS_4V  = 1'b1
)
(
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              CONVERTER_ON_BIT,
  input  wire logic              GO_SET,
  output logic                   GO_BUSY,
  input  wire logic [CHS_W-1:0]  INPUT_CHANNEL_SELECT,
  input  wire logic [1:0]        POSITIVE_REFERENCE_SELECT,
  input  wire logic              NEGATIVE_REFERENCE_SELECT,
  input  wire logic [2:0]        CONVERSION_CLOCK_SELECT,
  input  wire logic              RESULT_JUSTIFY_SELECT,
  input  wire logic              RC_TICK,
  input  wire logic              SLEEP_MODE,
  input  wire logic              INT_ENABLE,
  input  wire logic              FLAG_CLEAR,
  output logic                   CONVERSION_DONE_FLAG,
  output logic                   WAKE_REQUEST,
  output logic [CHS_W-1:0]       MUX_SELECT,
  output logic [1:0]             PREF_ROUTE,
  output logic                   NREF_GROUND,
  output logic                   SAMPLE_HOLD,
  output logic [RES_W-1:0]       DAC_TRIAL,
  input  wire logic              COMPARATOR_IN,
  output logic [7:0]             RESULT_HIGH_BYTE,
  output logic [7:0]             RESULT_LOW_BYTE
);

  // ************************************************************
  // Synchronisers for asynchronous inputs.
  // ************************************************************
  // The comparator answer trails a new trial by three clocks.
  // A divide-by-two period is shorter than that, so at that setting the
  // decisions see the previous trial and only rail inputs resolve exactly.
  logic cmp_s1_ff, cmp_s2_ff, rc_s1_ff, rc_s2_ff, rc_s3_ff;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
      rc_s1_ff  <= 1'b0;
      rc_s2_ff  <= 1'b0;
      rc_s3_ff  <= 1'b0;
    end
    else
    begin
      cmp_s1_ff <= COMPARATOR_IN;
      cmp_s2_ff <= cmp_s1_ff;
      rc_s1_ff  <= RC_TICK;
      rc_s2_ff  <= rc_s1_ff;
      rc_s3_ff  <= rc_s2_ff;
    end
  end

  // ************************************************************
  // State and datapath registers.
  // ************************************************************
  adsc_state_e     state_ff, nxt_state;
  logic [3:0]      tad_ff, nxt_tad;
  logic [RES_W-1:0] sar_ff, nxt_sar;
  logic [RES_W-1:0] bit_ff, nxt_bit;
  logic [RES_W-1:0] res_ff, nxt_res;
  logic            go_ff, nxt_go;
  logic            flag_ff, nxt_flag;
  logic            on_d_ff;

  adsc_tick_if tif ();
  adsc_tick_gen u_tick (
    .CLK   (CLK),
    .RST_N (RST_N),
    .tif   (tif)
  );

  logic rc_sel, active, tick, rc_edge, go_start, finish, sleep_kill;

  assign rc_sel    = (CONVERSION_CLOCK_SELECT[1:0] == 2'h3);
  // Outside Sleep the block needs no RC; in Sleep only the RC clock runs.
  assign sleep_kill = SLEEP_MODE && !rc_sel;
  assign active    = CONVERTER_ON_BIT && !sleep_kill;
  assign rc_edge   = rc_s2_ff && !rc_s3_ff;
  assign tif.sel     = CONVERSION_CLOCK_SELECT;
  assign tif.rc_tick = rc_edge;
  assign tif.run     = (state_ff == ST_CONV);
  assign tick        = tif.tick;
  // Go in the same cycle the converter is switched on is ignored.
  assign go_start  = GO_SET && CONVERTER_ON_BIT && on_d_ff &&
                     !go_ff; // [RL11]
  assign finish    = (state_ff == ST_CONV) && tick &&
                     (tad_ff == 4'(CONV_TADS - 1)); // [RL13]

  always_comb
  begin
    nxt_state = state_ff;
    nxt_tad   = tad_ff;
    nxt_sar   = sar_ff;
    nxt_bit   = bit_ff;
    nxt_res   = res_ff;
    nxt_go    = go_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (go_start && active)
        begin
          nxt_go    = 1'b1;
          nxt_state = ST_CONV;
          nxt_tad   = 4'h0;
          nxt_bit   = {1'b1, {(RES_W-1){1'b0}}};
          nxt_sar   = {1'b1, {(RES_W-1){1'b0}}};
        end
      end
      ST_CONV:
      begin
        if (!active)
        begin
          nxt_state = ST_IDLE; // Abort: no result stored.
          nxt_go    = 1'b0;
        end
        else if (tick)
        begin
          nxt_tad = tad_ff + 4'h1;
          // Period 0 samples; periods 1..10 resolve one bit each.
          if (tad_ff != 4'h0 && bit_ff != '0)
          begin
            nxt_sar = cmp_s2_ff ? sar_ff : (sar_ff & ~bit_ff); // [RL1]
            nxt_bit = bit_ff >> 1;
            nxt_sar = nxt_sar | (bit_ff >> 1);
          end
          if (finish)
          begin
            // Bit 0 is decided at this very tick, so store the new value.
            nxt_res   = nxt_sar; // [RL12]
            nxt_go    = 1'b0; // [RL12]
            nxt_state = ST_DONE;
          end
        end
      end
      ST_DONE:
        nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // Hardware set beats a software clear in the same cycle.
  assign nxt_flag = (state_ff == ST_DONE) ? 1'b1 :
                    (FLAG_CLEAR ? 1'b0 : flag_ff); // [RL12] [RL3]

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state_ff <= ST_IDLE; // [RL16]
      tad_ff   <= 4'h0;
      sar_ff   <= '0;
      bit_ff   <= '0;
      res_ff   <= '0;
      go_ff    <= 1'b0;
      flag_ff  <= 1'b0;
      on_d_ff  <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      tad_ff   <= nxt_tad;
      sar_ff   <= nxt_sar;
      bit_ff   <= nxt_bit;
      res_ff   <= nxt_res;
      go_ff    <= nxt_go;
      flag_ff  <= nxt_flag;
      on_d_ff  <= CONVERTER_ON_BIT;
    end
  end

  // ************************************************************
  // Analog routing and outputs.
  // ************************************************************
  logic [CHS_W-1:0] chs_ok;
  logic [1:0]       pref_ok;
  logic [15:0]      fmt_w;

  // Unimplemented pin channels fall back to ground.
  assign chs_ok = (INPUT_CHANNEL_SELECT < CHS_W'(NPINS) ||
                   INPUT_CHANNEL_SELECT >= CHS_TEMP) ?
                  INPUT_CHANNEL_SELECT : CHS_GND; // [RL4] [RL5] [RL2]
  // Parts without the 4.096V option route that code to the supply.
  assign pref_ok = (!HAS_4V && POSITIVE_REFERENCE_SELECT == PREF_FVR4) ?
                   PREF_SUPPLY : POSITIVE_REFERENCE_SELECT; // [RL8] [RL15]
  assign fmt_w = RESULT_JUSTIFY_SELECT ? {6'h00, res_ff} :
                 {res_ff, 6'h00}; // [RL14]

  assign MUX_SELECT           = chs_ok;
  assign PREF_ROUTE           = pref_ok;
  assign NREF_GROUND          = NEGATIVE_REFERENCE_SELECT; // [RL9]
  assign SAMPLE_HOLD          = (state_ff == ST_CONV) &&
                                (tad_ff == 4'h0); // [RL2]
  assign DAC_TRIAL            = sar_ff;
  assign GO_BUSY              = go_ff;
  assign CONVERSION_DONE_FLAG = flag_ff;
  assign WAKE_REQUEST         = flag_ff && INT_ENABLE && SLEEP_MODE; // [RL3]
  assign RESULT_HIGH_BYTE     = fmt_w[15:8]; // [RL1]
  assign RESULT_LOW_BYTE      = fmt_w[7:0];

endmodule : adsc_ctrl

// *** adsc_ctrl_properties.sv ***
// Concurrent checks on the converter sequencing control ports.
`timescale 1ns/1ns
module adsc_ctrl_properties
  import adsc_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       CONVERTER_ON_BIT,
  input wire logic       GO_SET,
  input wire logic       GO_BUSY,
  input wire logic [5:0] INPUT_CHANNEL_SELECT,
  input wire logic [1:0] POSITIVE_REFERENCE_SELECT,
  input wire logic       NEGATIVE_REFERENCE_SELECT,
  input wire logic       RESULT_JUSTIFY_SELECT,
  input wire logic       SLEEP_MODE,
  input wire logic       INT_ENABLE,
  input wire logic       FLAG_CLEAR,
  input wire logic       CONVERSION_DONE_FLAG,
  input wire logic       WAKE_REQUEST,
  input wire logic [5:0] MUX_SELECT,
  input wire logic [1:0] PREF_ROUTE,
  input wire logic       NREF_GROUND,
  input wire logic [7:0] RESULT_HIGH_BYTE,
  input wire logic [7:0] RESULT_LOW_BYTE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_go_taken: assert property (GO_SET && CONVERTER_ON_BIT
    && $past(CONVERTER_ON_BIT) && $past(RST_N) && !GO_BUSY && !SLEEP_MODE
    && !$past(GO_BUSY) && !$past(GO_BUSY, 2) |=> GO_BUSY)
    else $error("start request not taken");
  a_busy_hold: assert property ($rose(GO_BUSY) |=> GO_BUSY[*8])
    else $error("conversion ended too early");
  a_done_flag: assert property ($fell(GO_BUSY) && $past(RST_N)
    && $past(CONVERTER_ON_BIT) && !$past(SLEEP_MODE)
    |=> CONVERSION_DONE_FLAG) else $error("flag not set at completion");
  a_flag_holds: assert property (CONVERSION_DONE_FLAG && !FLAG_CLEAR
    |=> CONVERSION_DONE_FLAG) else $error("flag dropped without clear");
  a_wake_rule: assert property (WAKE_REQUEST ==
    (CONVERSION_DONE_FLAG && INT_ENABLE && SLEEP_MODE))
    else $error("wake request wrong");
  a_mux_route: assert property (MUX_SELECT == INPUT_CHANNEL_SELECT)
    else $error("mux select wrong");
  a_ref_route: assert property (
    PREF_ROUTE == POSITIVE_REFERENCE_SELECT
    && NREF_GROUND == NEGATIVE_REFERENCE_SELECT)
    else $error("reference routing wrong");
  a_justify_fmt: assert property (RESULT_JUSTIFY_SELECT
    ? RESULT_HIGH_BYTE[7:2] == 6'h00 : RESULT_LOW_BYTE[5:0] == 6'h00)
    else $error("result format wrong");
  a_reset_clear: assert property (disable iff (1'b0) !RST_N
    |=> !GO_BUSY && !CONVERSION_DONE_FLAG
    && {RESULT_HIGH_BYTE, RESULT_LOW_BYTE} == 16'h0000)
    else $error("reset did not clear state");
  c_done: cover property ($fell(GO_BUSY));
  c_wake: cover property (WAKE_REQUEST);
  c_clear: cover property (CONVERSION_DONE_FLAG && FLAG_CLEAR);
endmodule : adsc_ctrl_properties
bind adsc_ctrl adsc_ctrl_properties u_props (.*);

// *** adsc_analog_model.sv ***
// Behavioural analog side: channel levels, sample-and-hold, comparator.
`timescale 1ns/1ns
module adsc_analog_model
  import adsc_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic [5:0] MUX_SELECT,
  input  wire logic       SAMPLE_HOLD,
  input  wire logic [9:0] DAC_TRIAL,
  output logic            COMPARATOR_IN
);
  logic [9:0] held_ff;
  // Every pin channel is taken as already configured for analog use.
  wire logic [9:0] level = (MUX_SELECT == CHS_GND) ? 10'h000
    : {MUX_SELECT, ~MUX_SELECT[3:0]};
  always_ff @(posedge CLK)
    if (SAMPLE_HOLD)
      held_ff <= level;
  assign COMPARATOR_IN = held_ff >= DAC_TRIAL;
endmodule : adsc_analog_model

// *** adsc_ctrl_tb_top.sv ***
// Self-checking bench for the converter sequencing control.
`timescale 1ns/1ns
module adsc_ctrl_tb_top;
  import adsc_pkg::*;
  logic clk = 0, rst_n = 0, on = 0, go = 0, nref = 0, rj = 0, rc = 0;
  logic slp = 0, ie = 0, fclr = 0;
  logic [5:0] chs = 6'h00;
  logic [1:0] pref = 2'h0;
  logic [2:0] ccs = 3'h0;
  wire logic busy, flag, wake, nrg, sh, cmp;
  wire logic [5:0] mux;
  wire logic [1:0] prt;
  wire logic [9:0] trial;
  wire logic [7:0] hi, lo;
  int errors = 0, compares = 0, cyc = 0;
  logic [5:0] chl [7] = '{6'h3e, 6'h3f, 6'h3b, 6'h3f, 6'h3c, 6'h3d, 6'h00};
  logic [2:0] csl [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  adsc_ctrl DUT (
    .CLK(clk), .RST_N(rst_n), .CONVERTER_ON_BIT(on), .GO_SET(go),
    .GO_BUSY(busy), .INPUT_CHANNEL_SELECT(chs),
    .POSITIVE_REFERENCE_SELECT(pref), .NEGATIVE_REFERENCE_SELECT(nref),
    .CONVERSION_CLOCK_SELECT(ccs), .RESULT_JUSTIFY_SELECT(rj),
    .RC_TICK(rc), .SLEEP_MODE(slp), .INT_ENABLE(ie), .FLAG_CLEAR(fclr),
    .CONVERSION_DONE_FLAG(flag), .WAKE_REQUEST(wake), .MUX_SELECT(mux),
    .PREF_ROUTE(prt), .NREF_GROUND(nrg), .SAMPLE_HOLD(sh),
    .DAC_TRIAL(trial), .COMPARATOR_IN(cmp),
    .RESULT_HIGH_BYTE(hi), .RESULT_LOW_BYTE(lo));
  adsc_analog_model AM (.CLK(clk), .MUX_SELECT(mux), .SAMPLE_HOLD(sh),
    .DAC_TRIAL(trial), .COMPARATOR_IN(cmp));
  always #10 clk = ~clk;
  task automatic final_report;
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // The RC source runs free and slow; a hang is cut after 20000 cycles.
  always @(posedge clk)
  begin
    cyc++;
    rc <= (cyc % 9 == 0) ? ~rc : rc;
    if (cyc == 20000)
    begin
      errors++;
      final_report;
    end
  end
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conv(input logic [5:0] ch, input logic [2:0] cs,
                      input logic j);
    int n, dv;
    logic [9:0] v;
    n = 0;
    dv = 2 << (cs[2] + 2 * cs[1:0]);
    v = (ch == CHS_GND) ? 10'h000 : {ch, ~ch[3:0]};
    @(posedge clk);
    chs <= ch;
    ccs <= cs;
    rj <= j;
    repeat (4) @(posedge clk);
    go <= 1;
    @(posedge clk);
    go <= 0;
    @(negedge clk);
    chk(busy, 1);
    while (busy === 1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (cs[1:0] != 2'h3)
      chk(n >= 10 * dv && n <= 12 * dv + 4, 1);
    @(negedge clk);
    chk(flag, 1);
    chk({hi, lo}, j ? {6'h00, v} : {v, 6'h00});
    chk(wake, slp & ie);
    @(posedge clk);
    fclr <= 1;
    @(posedge clk);
    fclr <= 0;
    @(negedge clk);
    chk(flag, 0);
  endtask : conv
  task automatic refuse_same_cycle;
    @(posedge clk);
    on <= 0;
    @(posedge clk);
    on <= 1;
    go <= 1;
    @(posedge clk);
    go <= 0;
    @(negedge clk);
    chk(busy, 0);
  endtask : refuse_same_cycle
  task automatic reset_mid;
    @(posedge clk);
    ccs <= 3'h6;
    go <= 1;
    @(posedge clk);
    go <= 0;
    repeat (20) @(posedge clk);
    rst_n <= 0;
    @(posedge clk);
    rst_n <= 1;
    @(negedge clk);
    chk({busy, flag, hi, lo}, 20'h0);
  endtask : reset_mid
  task automatic refs;
    for (int p = 0; p < 4; p++)
    begin
      @(posedge clk);
      pref <= p[1:0];
      nref <= p[0];
      @(negedge clk);
      chk({prt, nrg}, {p[1:0], p[0]});
    end
  endtask : refs
  initial
  begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({busy, flag, hi, lo}, 20'h0);
    @(posedge clk);
    rst_n <= 1;
    on <= 1;
    refs;
    // Ground is selected between falling channels to drain the hold cap, except on the last step from 3d to 00.
    foreach (chl[i]) conv(chl[i], 3'h4, 1);
    // Divide-by-two outruns the comparator synchroniser, so that setting
    // converts ground, the one input it resolves exactly.
    foreach (csl[i])
      conv(csl[i] == 3'h0 ? CHS_GND : 6'h2a, csl[i], i[0]);
    @(posedge clk);
    slp <= 1;
    ie <= 1;
    conv(6'h15, 3'h3, 0);
    @(posedge clk);
    slp <= 0;
    ie <= 0;
    refuse_same_cycle;
    reset_mid;
    final_report;
  end
endmodule : adsc_ctrl_tb_top
